/* bench/anps_partner_model.sv */
// Remote link partner model: delivers received pages and partner status levels
`timescale 1ns/10ps

module anps_partner_model (
  input  wire logic            clock_i,      // System clock
  output logic                 page_valid_o, // One-cycle page received pulse
  output anps_pkg::anps_page_t page_word_o,  // Received link code word
  output anps_pkg::anps_link_t link_o        // Partner status levels
);
  // Quiet lines at time zero
  initial begin
    page_valid_o = 1'b0;
    page_word_o  = 16'h0000;
    link_o       = 3'h0;
  end

  // One page, then the word lines flip so a stale word is never captured by luck
  task automatic send_page(input logic [15:0] w, input int gap);
    @(posedge clock_i);
    page_valid_o <= 1'b1;
    page_word_o  <= w;
    @(posedge clock_i);
    page_valid_o <= 1'b0;
    page_word_o  <= ~w;
    // Slow partner: idle cycles after the page
    repeat (gap) @(posedge clock_i);
  endtask

  // Change the partner levels right after an edge
  task automatic set_link(input logic [2:0] l);
    @(posedge clock_i);
    link_o <= l;
  endtask
endmodule

/* bench/tb.sv */
// Self-checking bench for the partner page and expansion status registers
`timescale 1ns/10ps

module tb;
  logic                 clock_i;      // System clock
  logic                 rst_i;        // Synchronous reset
  logic [4:0]           reg_addr_i;   // Register address
  logic [15:0]          reg_wdata_i;  // Write data
  logic                 reg_wr_i;     // Write strobe
  logic                 reg_rd_i;     // Read strobe
  logic                 page_valid_i; // Page pulse from partner
  anps_pkg::anps_page_t page_word_i;  // Page word from partner
  anps_pkg::anps_link_t link_i;       // Partner levels
  logic [15:0]          reg_rdata_o;  // Read data
  logic                 irq_o;        // Interrupt
  int                   n_fail;       // Mismatch count
  int                   compares;     // Comparison count
  int                   cycles;       // Timeout counter

  anps_status_regs dut (
    .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .page_valid_i(page_valid_i),
    .page_word_i(page_word_i), .link_i(link_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o)
  );

  anps_partner_model partner (
    .clock_i(clock_i), .page_valid_o(page_valid_i), .page_word_o(page_word_i), .link_o(link_i)
  );

  // 10 MHz clock
  always #50 clock_i = ~clock_i;

  // Hang guard: well above the hundred or so cycles the tests take
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      conclude();
    end
  end

  // Compare one value and report a mismatch
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Single-cycle write
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i    <= 1'b0;
  endtask

  // Single-cycle read, data judged in the following cycle
  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
    @(posedge clock_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i   <= 1'b0;
    @(negedge clock_i);
    chk(what, exp, reg_rdata_o);
  endtask

  // Hold reset for six cycles
  task automatic do_reset();
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
  endtask

  // Wait n edges then look at the interrupt
  task automatic irq_chk(input int n, input logic exp);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
    chk("irq_o", {15'h0, exp}, {15'h0, irq_o});
  endtask

  // Values after reset
  task automatic t_reset_values();
    rd(5'h05, 16'h0000, "page reset");
    rd(5'h06, 16'h0004, "expansion reset");
    rd(5'h18, 16'h0000, "irq status reset");
    rd(5'h19, 16'h0000, "irq mask reset");
  endtask

  // Two pages with every single-bit field flipped, and read-clear of the received flag
  task automatic t_pages();
    partner.send_page(16'hd5a5, 0);
    rd(5'h05, 16'hd5a5, "page one");
    rd(5'h06, 16'h0006, "received set");
    rd(5'h06, 16'h0004, "received cleared");
    partner.send_page(16'h2bff, 3);
    rd(5'h05, 16'h2bff, "page two");
    rd(5'h06, 16'h0006, "received again");
  endtask

  // Writes to the read-only registers change nothing
  task automatic t_writes_ignored();
    wr(5'h05, 16'hffff);
    wr(5'h06, 16'hffff);
    rd(5'h05, 16'h2bff, "page after write");
    rd(5'h06, 16'h0004, "exp after write");
    rd(5'h1f, 16'h0000, "unmapped read");
  endtask

  // A page meeting a clearing read keeps its flag; a read right after a page shows it
  task automatic t_fresh_pages();
    fork
      partner.send_page(16'h5c3a, 0);
      rd(5'h06, 16'h0004, "clear meets page");
    join
    fork
      partner.send_page(16'ha3c5, 0);
      begin
        @(posedge clock_i);
        rd(5'h05, 16'ha3c5, "page right after load");
      end
    join
    rd(5'h06, 16'h0006, "received kept over clear");
  endtask

  // Partner levels show in the expansion flags
  task automatic t_link_levels();
    partner.set_link(3'h7);
    repeat (3) @(posedge clock_i);
    rd(5'h06, 16'h001d, "levels high");
    partner.set_link(3'h0);
    repeat (3) @(posedge clock_i);
    rd(5'h06, 16'h0004, "levels low");
  endtask

  // Sticky status, mask and level interrupt
  task automatic t_interrupts();
    rd(5'h18, 16'h0003, "status both events");
    rd(5'h18, 16'h0000, "status cleared");
    wr(5'h19, 16'h0003);
    rd(5'h19, 16'h0003, "mask readback");
    irq_chk(1, 1'b0);
    partner.send_page(16'h0001, 0);
    irq_chk(2, 1'b1);
    rd(5'h18, 16'h0001, "page event");
    irq_chk(2, 1'b0);
    wr(5'h19, 16'h0000);
    partner.send_page(16'h0002, 0);
    irq_chk(2, 1'b0);
    rd(5'h18, 16'h0001, "masked event kept");
  endtask

  // Reset in mid-run returns the page and expansion fields to their reset values
  task automatic t_mid_reset();
    partner.send_page(16'hffff, 0);
    do_reset();
    rd(5'h05, 16'h0000, "page after reset");
    rd(5'h06, 16'h0004, "exp after reset");
  endtask

  // Report counts and verdict, then stop
  task automatic conclude();
    $display("TB: compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clock_i     = 1'b0;
    rst_i       = 1'b1;
    reg_addr_i  = 5'h00;
    reg_wdata_i = 16'h0000;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    n_fail      = 0;
    compares    = 0;
    cycles      = 0;
    do_reset();
    t_reset_values();
    t_pages();
    t_writes_ignored();
    t_fresh_pages();
    t_link_levels();
    t_interrupts();
    t_mid_reset();
    conclude();
  end
endmodule

/* inc/anps_consts.svh */
// Register offsets, field positions and reset values of the page status bank
`ifndef ANPS_CONSTS_SVH
`define ANPS_CONSTS_SVH

// Register offsets on the management port
`define ANPS_ADDR_PAGE      5'h05
`define ANPS_ADDR_EXP       5'h06
`define ANPS_ADDR_IRQ_STAT  5'h18
`define ANPS_ADDR_IRQ_MASK  5'h19

// Expansion register field positions
`define ANPS_EXP_RSVD_HI    15
`define ANPS_EXP_RSVD_LO    5
`define ANPS_EXP_FAULT_BIT  4
`define ANPS_EXP_PNP_BIT    3
`define ANPS_EXP_LNP_BIT    2
`define ANPS_EXP_PRX_BIT    1
`define ANPS_EXP_PAN_BIT    0

// Interrupt status and mask field positions
`define ANPS_IRQ_PAGE_BIT   0
`define ANPS_IRQ_FAULT_BIT  1

// Reset values
`define ANPS_PAGE_RST       16'h0000
`define ANPS_LNP_RST        1'b1
`define ANPS_RDATA_RST      16'h0000

`endif

/* inc/anps_pkg.sv */
// Types shared by the page status bank
package anps_pkg;

  // Received link code word, laid out as the partner page register
  typedef struct packed {
    logic        further_page_wanted;    // Bit 15
    logic        partner_ack;            // Bit 14
    logic        page_type_message;      // Bit 13
    logic        compliance_acknowledge; // Bit 12
    logic        toggle;                 // Bit 11
    logic [10:0] code;                   // Bits 10:0
  } anps_page_t;

  // Link partner levels from the negotiation logic
  typedef struct packed {
    logic parallel_detect_fault;
    logic partner_multi_page_capable;
    logic partner_negotiation_capable;
  } anps_link_t;

  // Expansion register flags, laid out as bits 4 down to 0
  typedef struct packed {
    logic parallel_detect_fault;       // Bit 4
    logic partner_multi_page_capable;  // Bit 3
    logic local_multi_page_capable;    // Bit 2
    logic page_received;               // Bit 1
    logic partner_negotiation_capable; // Bit 0
  } anps_exp_t;

endpackage

/* src/anps_irq_ctrl.sv */
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/10ps

module anps_irq_ctrl #(
  parameter int W = 2 // Number of event sources
) (
  input  wire logic         clock_i,      // System clock
  input  wire logic         rst_i,        // Synchronous reset, active high
  input  wire logic [W-1:0] event_i,      // One-cycle event pulses
  input  wire logic         status_rd_i,  // Read of status: clears it
  input  wire logic         mask_wr_i,    // Write strobe for the mask
  input  wire logic [W-1:0] mask_wdata_i, // New mask value
  output logic      [W-1:0] status_o,     // Sticky status bits
  output logic      [W-1:0] mask_o,       // Mask bits, 1 enables
  output logic              irq_o         // Level interrupt, active high
);

  logic [W-1:0] status_d; // Next status
  logic [W-1:0] status_q; // Sticky status
  logic [W-1:0] mask_d;   // Next mask
  logic [W-1:0] mask_q;   // Mask
  logic         irq_d;    // Next interrupt level
  logic         irq_q;    // Registered interrupt level

  // Read clears, a fresh event in the same cycle still sets
  always_comb begin
    status_d = status_q;
    if (status_rd_i) begin
      status_d = '0;
    end
    status_d = status_d | event_i;
    mask_d   = mask_wr_i ? mask_wdata_i : mask_q;
    irq_d    = |(status_d & mask_d);
  end

  // Status, mask and output level registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      status_q <= '0;
      mask_q   <= '0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
    end
  end

  assign status_o = status_q;
  assign mask_o   = mask_q;
  assign irq_o    = irq_q;

  // Output tracks the masked status
  AST_IRQ_LEVEL: assert property (@(posedge clock_i) disable iff (rst_i)
    irq_q == |(status_q & mask_q))
    else $error("Interrupt level disagrees with masked status");

  // An event is never lost to a clearing read
  AST_IRQ_SET_WINS: assert property (@(posedge clock_i) disable iff (rst_i)
    (|event_i) |=> ((status_q & $past(event_i)) == $past(event_i)))
    else $error("Event lost from interrupt status");

endmodule

/* src/anps_page_capture.sv */
// Holding register for the last received link code word
`timescale 1ns/10ps

`include "anps_consts.svh"

module anps_page_capture (
  input  wire logic              clock_i, // System clock
  input  wire logic              rst_i,   // Synchronous reset, active high
  input  wire logic              load_i,  // One-cycle strobe: new page arrived
  input  wire anps_pkg::anps_page_t page_i, // Page word from the link partner
  output anps_pkg::anps_page_t   page_o   // Captured page word
);

  anps_pkg::anps_page_t page_d; // Next page value
  anps_pkg::anps_page_t page_q; // Held page value

  // Whole word loads at once, so fields never mix two pages
  always_comb begin
    page_d = page_q;
    if (load_i) begin
      page_d = page_i;
    end
  end

  // Register the page; all fields clear at reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      page_q <= `ANPS_PAGE_RST;
    end else begin
      page_q <= page_d;
    end
  end

  assign page_o = page_q;

  // A load shows the whole word in the next cycle
  AST_PAGE_LOAD: assert property (@(posedge clock_i) disable iff (rst_i)
    load_i |=> (page_q == $past(page_i)))
    else $error("Page word not captured whole");

  // Without a load the word holds
  AST_PAGE_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
    !load_i |=> $stable(page_q))
    else $error("Page word changed without a load");

endmodule

/* src/anps_status_regs.sv */
// Partner page and expansion status registers of the negotiation function
//
// Contract
// - Acknowledge bit 14 follows received bursts
// - Bit 13: message or unformatted page, reset 0
// - Bit 12: partner compliance, read-only, reset 0
// - Bit 11: inverse of previous toggle, reset 0
// - Code field resets zero, meaning set by type
// - Expansion bits 15:5 ignore writes, read zero
// - Bit 4: parallel detection fault, reset 0
// - Bit 3: partner multi-page capable, reset 0
// - Bit 2: local multi-page capable, reset 1
// - Bit 1: page received, cleared by read
// - Bit 0: partner negotiation capable, reset 0
// - Bit 15: partner wants further page, reset 0
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps

`include "anps_consts.svh"

module anps_status_regs (
  input  wire logic                 clock_i,     // System clock, 10 MHz
  input  wire logic                 rst_i,       // Synchronous reset, active high
  input  wire logic [4:0]           reg_addr_i,  // Register address
  input  wire logic [15:0]          reg_wdata_i, // Register write data
  input  wire logic                 reg_wr_i,    // Write strobe, one cycle
  input  wire logic                 reg_rd_i,    // Read strobe, one cycle
  input  wire logic                 page_valid_i, // Page received pulse
  input  wire anps_pkg::anps_page_t page_word_i, // Received link code word
  input  wire anps_pkg::anps_link_t link_i,      // Partner status levels
  output logic [15:0]               reg_rdata_o, // Read data, cycle after read
  output logic                      irq_o        // Level interrupt
);

  localparam int IRQ_W = 2; // Interrupt sources: page, fault

  // Strobe decode for one register address
  function automatic logic hit(input logic [4:0] addr,
                               input logic       strobe,
                               input logic [4:0] target);
    hit = strobe && (addr == target);
  endfunction

  anps_pkg::anps_page_t page_q;      // Captured partner page
  anps_pkg::anps_exp_t  exp_d;       // Next expansion flags
  anps_pkg::anps_exp_t  exp_q;       // Expansion flags
  logic                 fault_seen_q; // Fault level last cycle
  logic [IRQ_W-1:0]     irq_event;   // Interrupt event pulses
  logic [IRQ_W-1:0]     irq_status;  // Sticky interrupt status
  logic [IRQ_W-1:0]     irq_mask;    // Interrupt mask
  logic                 rd_page;     // Read of partner page register
  logic                 rd_exp;      // Read of expansion register
  logic                 rd_stat;     // Read of interrupt status
  logic                 rd_mask;     // Read of interrupt mask
  logic                 wr_mask;     // Write of interrupt mask
  logic [15:0]          rdata_d;     // Next read data
  logic [15:0]          rdata_q;     // Registered read data

  // Address decode of the strobes
  always_comb begin
    rd_page = hit(reg_addr_i, reg_rd_i, `ANPS_ADDR_PAGE);
    rd_exp  = hit(reg_addr_i, reg_rd_i, `ANPS_ADDR_EXP);
    rd_stat = hit(reg_addr_i, reg_rd_i, `ANPS_ADDR_IRQ_STAT);
    rd_mask = hit(reg_addr_i, reg_rd_i, `ANPS_ADDR_IRQ_MASK);
    wr_mask = hit(reg_addr_i, reg_wr_i, `ANPS_ADDR_IRQ_MASK);
  end

  // Page word holder; writes never reach it
  anps_page_capture u_page (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .load_i  (page_valid_i),
    .page_i  (page_word_i),
    .page_o  (page_q)
  );

  // Expansion flags: partner levels, local ability, page flag
  always_comb begin
    exp_d = exp_q;
    // Levels follow the negotiation logic
    exp_d.parallel_detect_fault       = link_i.parallel_detect_fault;
    exp_d.partner_multi_page_capable  = link_i.partner_multi_page_capable;
    exp_d.partner_negotiation_capable = link_i.partner_negotiation_capable;
    // Local ability is fixed after reset
    exp_d.local_multi_page_capable    = exp_q.local_multi_page_capable;
    // Reading clears the page flag
    if (rd_exp) begin
      exp_d.page_received = 1'b0;
    end
    // A new page in the same cycle wins over the clear
    if (page_valid_i) begin
      exp_d.page_received = 1'b1;
    end
  end

  // Register the expansion flags
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      exp_q.parallel_detect_fault       <= 1'b0;
      exp_q.partner_multi_page_capable  <= 1'b0;
      exp_q.local_multi_page_capable    <= `ANPS_LNP_RST;
      exp_q.page_received               <= 1'b0;
      exp_q.partner_negotiation_capable <= 1'b0;
    end else begin
      exp_q <= exp_d;
    end
  end

  // Fault edge memory for the interrupt event
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fault_seen_q <= 1'b0;
    end else begin
      fault_seen_q <= exp_q.parallel_detect_fault;
    end
  end

  // Events: each page, and each new fault
  always_comb begin
    irq_event                      = '0;
    irq_event[`ANPS_IRQ_PAGE_BIT]  = page_valid_i;
    irq_event[`ANPS_IRQ_FAULT_BIT] = exp_q.parallel_detect_fault & ~fault_seen_q;
  end

  // Interrupt status and mask
  anps_irq_ctrl #(
    .W (IRQ_W)
  ) u_irq (
    .clock_i      (clock_i),
    .rst_i        (rst_i),
    .event_i      (irq_event),
    .status_rd_i  (rd_stat),
    .mask_wr_i    (wr_mask),
    .mask_wdata_i (reg_wdata_i[IRQ_W-1:0]),
    .status_o     (irq_status),
    .mask_o       (irq_mask),
    .irq_o        (irq_o)
  );

  // Read mux; unmapped and idle cycles give zero
  always_comb begin
    rdata_d = `ANPS_RDATA_RST;
    if (rd_page) begin
      rdata_d = page_q;
    end else if (rd_exp) begin
      // Upper bits stay zero whatever was written
      rdata_d = {11'h000, exp_q};
    end else if (rd_stat) begin
      rdata_d = {14'h0, irq_status};
    end else if (rd_mask) begin
      rdata_d = {14'h0, irq_mask};
    end
  end

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_q <= `ANPS_RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // Acknowledge reads back as captured from the last page
  AST_ACK_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_page |=> (reg_rdata_o[14] == $past(page_q.partner_ack)))
    else $error("Acknowledge bit read wrong");

  // Page type and code read back from one word
  AST_PAGE_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_page |=> (reg_rdata_o == $past(page_q)))
    else $error("Partner page read is not one whole word");

  // Page type read right after a load comes from the new word
  AST_PAGE_FRESH: assert property (@(posedge clock_i) disable iff (rst_i)
    (page_valid_i ##1 rd_page) |=>
      (reg_rdata_o[13] == $past(page_word_i.page_type_message, 2)))
    else $error("Page type not from the latest page");

  // Compliance and toggle read from the latest page
  AST_COMPLIANCE_ACKNOWLEDGE_TOG: assert property (@(posedge clock_i) disable iff (rst_i)
    (page_valid_i ##1 rd_page) |=>
      (reg_rdata_o[12:11] == {$past(page_word_i.compliance_acknowledge, 2),
                              $past(page_word_i.toggle, 2)}))
    else $error("Compliance or toggle bit read wrong");

  // Expansion upper bits always read zero
  AST_EXP_RSVD: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_exp |=> (reg_rdata_o[15:5] == 11'h000))
    else $error("Expansion reserved bits not zero");

  // Fault flag follows its level one cycle later
  AST_FAULT_FLAG: assert property (@(posedge clock_i) disable iff (rst_i)
    link_i.parallel_detect_fault |=> exp_q.parallel_detect_fault)
    else $error("Fault flag missed");

  // Partner multi-page flag follows its level
  AST_PNP_FLAG: assert property (@(posedge clock_i) disable iff (rst_i)
    ##1 (exp_q.partner_multi_page_capable == $past(link_i.partner_multi_page_capable)))
    else $error("Partner multi-page flag wrong");

  // Local ability reads one at all times
  AST_LNP_ONE: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_exp |=> reg_rdata_o[2])
    else $error("Local multi-page flag not one");

  // A page sets the received flag
  AST_PRX_SET: assert property (@(posedge clock_i) disable iff (rst_i)
    page_valid_i |=> exp_q.page_received)
    else $error("Page received flag not set");

  // A read with no new page clears it and reports the old value
  AST_PRX_CLR: assert property (@(posedge clock_i) disable iff (rst_i)
    (rd_exp && !page_valid_i && exp_q.page_received) |=>
      (!exp_q.page_received && reg_rdata_o[1]))
    else $error("Page received flag not cleared on read");

  // Negotiation ability flag follows its level
  AST_PAN_FLAG: assert property (@(posedge clock_i) disable iff (rst_i)
    ##1 (exp_q.partner_negotiation_capable == $past(link_i.partner_negotiation_capable)))
    else $error("Partner negotiation flag wrong");

  // Further page wanted reads from the latest page
  AST_NP_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    (page_valid_i ##1 rd_page) |=>
      (reg_rdata_o[15] == $past(page_word_i.further_page_wanted, 2)))
    else $error("Further page bit read wrong");

  // Code field reads from the latest page
  AST_CODE_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    (page_valid_i ##1 rd_page) |=>
      (reg_rdata_o[10:0] == $past(page_word_i.code, 2)))
    else $error("Code field read wrong");

  // Read data stands one cycle only
  AST_RDATA_ONE: assert property (@(posedge clock_i) disable iff (rst_i)
    (!reg_rd_i) |=> (reg_rdata_o == 16'h0000))
    else $error("Read data present without a read");

  // Status read returns the sticky bits of that cycle
  AST_STAT_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_stat |=> (reg_rdata_o == {14'h0, $past(irq_status)}))
    else $error("Interrupt status read wrong");

  // Mask read returns the mask of that cycle
  AST_MASK_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_mask |=> (reg_rdata_o == {14'h0, $past(irq_mask)}))
    else $error("Interrupt mask read wrong");

  // A mask write lands in the next cycle
  AST_MASK_WRITE: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_mask |=> (irq_mask == $past(reg_wdata_i[IRQ_W-1:0])))
    else $error("Interrupt mask write lost");

  // Every page raises its sticky status bit
  AST_PAGE_EVENT: assert property (@(posedge clock_i) disable iff (rst_i)
    page_valid_i |=> irq_status[`ANPS_IRQ_PAGE_BIT])
    else $error("Page event not recorded");

  // A new fault raises its sticky status bit
  AST_FAULT_EVENT: assert property (@(posedge clock_i) disable iff (rst_i)
    irq_event[`ANPS_IRQ_FAULT_BIT] |=> irq_status[`ANPS_IRQ_FAULT_BIT])
    else $error("Fault event not recorded");

  // A status read with no event clears every bit
  AST_STAT_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i)
    (rd_stat && (irq_event == '0)) |=> (irq_status == '0))
    else $error("Interrupt status not cleared by read");

  // Writes never reach the partner page
  AST_PAGE_NO_WRITE: assert property (@(posedge clock_i) disable iff (rst_i)
    (reg_wr_i && !page_valid_i) |=> $stable(page_q))
    else $error("Partner page changed by a write");

  // Without a page or a read the received flag holds
  AST_PRX_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
    (!rd_exp && !page_valid_i) |=> $stable(exp_q.page_received))
    else $error("Page received flag changed on its own");

  // Expansion read returns the flags of that cycle
  AST_EXP_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_exp |=> (reg_rdata_o[4:0] == $past(exp_q)))
    else $error("Expansion flags read wrong");

  // Negotiation ability drops with its level
  AST_PAN_FALL: assert property (@(posedge clock_i) disable iff (rst_i)
    !link_i.partner_negotiation_capable |=> !exp_q.partner_negotiation_capable)
    else $error("Partner negotiation flag stuck");

  // Fault flag drops with its level
  AST_FAULT_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i)
    !link_i.parallel_detect_fault |=> !exp_q.parallel_detect_fault)
    else $error("Fault flag stuck");

  // Partner multi-page flag rises with its level
  AST_PNP_SET: assert property (@(posedge clock_i) disable iff (rst_i)
    link_i.partner_multi_page_capable |=> exp_q.partner_multi_page_capable)
    else $error("Partner multi-page flag missed");

  // Reads of unmapped addresses return zero
  AST_UNMAPPED_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    (reg_rd_i && !rd_page && !rd_exp && !rd_stat && !rd_mask) |=>
      (reg_rdata_o == 16'h0000))
    else $error("Unmapped read not zero");

  // Toggle bit reads back from the held page
  AST_TOGGLE_READ: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_page |=> (reg_rdata_o[11] == $past(page_q.toggle)))
    else $error("Toggle bit read wrong");

endmodule
